// ---- core/pwm_cfg_pkg.sv ----
// Package: register map, fields, angle scale and drive table of the commutation PWM
// Behaviour
// - Shape bit clear: peak duty times per-phase sine envelope.
// - Shape bit set: phases driven in turn, duty ramped at interval ends.
// - Two-phase bit clear, shape bit clear: all three phases switch PWM, except the floating phase while the bemf window is open.
// - Two-phase bit set, shape bit clear: one phase held low, other two switch PWM, except the floating phase while the bemf window is open.
// - Trapezoid walks six table states; direction bit picks the way.
// - High: only high switch on; low: only low switch; float: both off.
// - Trapezoid duty ramps between minimum and maximum duty.
// - Overmod codes 1, 2, 3 give 112.5, 125, 150 percent; 0 disables.
// - Overmod factor scales every duty, saturating at full duty.
// - Floating phase compared with centre reference gives the zero crossing.
// - Centre reference follows bridge levels in PWM on and off.
// - Zero crossings correct estimated position and commutation rate.
// - Window code steps 1.4 degrees from 1.4 to 43.4; code 31 is 60.
package pwm_cfg_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DUTY = 8'h04;
  localparam logic [7:0] ADDR_SPEED = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  // Field positions
  localparam int F_SHAPE = 0;
  localparam int F_TWO_PH = 1;
  localparam int F_DIR = 2;
  localparam int F_ADV = 3;
  localparam int F_OVM = 4;
  localparam int F_BW = 6;
  localparam int F_RUN = 11;
  localparam int F_MIN = 8;
  // Reset values
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [7:0] PEAK_RST = 8'h80;
  localparam logic [7:0] MIN_RST = 8'h00;
  localparam logic [15:0] SPEED_RST = 16'h0100;
  // Angle scale: 256 counts per 60 degree sector
  localparam int SECTOR = 256;
  localparam logic [11:0] CYCLE = 12'h600;
  localparam logic [10:0] CYCLE_LAST = 11'h5ff;
  localparam logic [10:0] HALF_CYCLE = 11'h300;
  localparam logic [7:0] MID = 8'h80;
  localparam int BW_STEP_TENTHS = 14;
  localparam int SECTOR_TENTHS = 600;
  localparam logic [4:0] BW_FULL = 5'h1f;
  localparam int RAMP_SHIFT = 6;
  localparam logic [6:0] RAMP_LEN = 7'h40;
  localparam logic [10:0] HI_LEN = 11'h200;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [7:0] CARRIER_LAST = 8'hfe;
  // Phase offsets: sine peak and start of high interval, A first
  localparam logic [10:0] SIN_OFS [3] = '{11'h580, 11'h380, 11'h180};
  localparam logic [10:0] HI_OFS [3] = '{11'h500, 11'h300, 11'h100};

  typedef enum logic [1:0] {DRV_Z = 2'b00, DRV_HI = 2'b01, DRV_LO = 2'b10} drive_t;

  // Angle addition modulo one electrical cycle
  function automatic logic [10:0] ang_add(input logic [10:0] a, input logic [10:0] b);
    logic [11:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s >= CYCLE) ? 11'(s - CYCLE) : s[10:0];
  endfunction : ang_add

  // Six-state table, sector 0 is state 1, phase 0 is A
  function automatic drive_t table_drive(input logic [2:0] sec, input logic [1:0] ph);
    logic [5:0] r;
    unique case (sec)
      3'h0: r = {DRV_Z, DRV_LO, DRV_HI};
      3'h1: r = {DRV_HI, DRV_LO, DRV_Z};
      3'h2: r = {DRV_HI, DRV_Z, DRV_LO};
      3'h3: r = {DRV_Z, DRV_HI, DRV_LO};
      3'h4: r = {DRV_LO, DRV_HI, DRV_Z};
      3'h5: r = {DRV_LO, DRV_Z, DRV_HI};
      default: r = 6'h00;
    endcase
    return drive_t'((ph == 2'h0) ? r[5:4] : (ph == 2'h1) ? r[3:2] : r[1:0]);
  endfunction : table_drive

  // Index of the floating phase in each sector
  function automatic logic [1:0] undriven_phase(input logic [2:0] sec);
    unique case (sec)
      3'h0, 3'h3: return 2'h0;
      3'h2, 3'h5: return 2'h1;
      default: return 2'h2;
    endcase
  endfunction : undriven_phase
endpackage : pwm_cfg_pkg

// ---- core/duty_shaper.sv ----
// Per-phase duty shaping: sine or trapezoid envelope, then overmodulation
`timescale 1ns/1ps
module duty_shaper (
  // Mode
  input wire logic shape,
  input wire logic two_phase,
  input wire logic [1:0] overmod_level,
  // Levels and electrical angle
  input wire logic [7:0] peak,
  input wire logic [7:0] min_duty,
  input wire logic [10:0] angle,
  // Duty per phase, index 0 is phase A
  output logic [2:0][7:0] duty
);
  // Parabolic half-wave sine, +-252; cheaper than a table
  function automatic logic signed [9:0] para_sin(input logic [10:0] th);
    logic [9:0] x;
    logic [21:0] p;
    x = (th >= pwm_cfg_pkg::HALF_CYCLE) ? 10'(th - pwm_cfg_pkg::HALF_CYCLE) : th[9:0];
    p = 22'(x) * 22'(10'h300 - x) * 22'h00_0007;
    return (th >= pwm_cfg_pkg::HALF_CYCLE) ? -$signed({2'b00, p[19:12]}) : $signed({2'b00, p[19:12]});
  endfunction : para_sin

  // Envelope, ramp and overmodulation for all phases
  always_comb begin
    logic signed [9:0] s [3];
    logic signed [9:0] s_min;
    logic [10:0] d;
    logic [18:0] m;
    logic [7:0] env;
    logic [15:0] raw;
    logic [10:0] p;
    logic [10:0] q;
    logic [14:0] span;
    logic [11:0] sc;
    s = '{10'sh000, 10'sh000, 10'sh000};
    d = 11'h000;
    m = 19'h0_0000;
    env = 8'h00;
    raw = 16'h0000;
    p = 11'h000;
    q = 11'h000;
    span = 15'h0000;
    sc = 12'h000;
    duty = '0;
    for (int i = 0; i < 3; i++) s[i] = para_sin(pwm_cfg_pkg::ang_add(angle, pwm_cfg_pkg::SIN_OFS[i]));
    s_min = s[0];
    if (s[1] < s_min) s_min = s[1];
    if (s[2] < s_min) s_min = s[2];
    for (int i = 0; i < 3; i++) begin
      if (!shape) begin
        if (two_phase) begin
          // Lowest phase sits at zero and stays low side on
          d = 11'(s[i]) - 11'(s_min);
          m = 19'(d) * 19'h0_0096;
          env = (m[18:16] != 3'h0) ? 8'hff : m[15:8];
        end else begin
          d = 11'(s[i]) + 11'h100;
          env = d[8:1];
        end
        raw = 16'(peak) * 16'(env);
        raw = {8'h00, raw[15:8]};
      end else begin
        // Ramp up and down across the 120 degree high interval
        p = pwm_cfg_pkg::ang_add(angle, pwm_cfg_pkg::HI_OFS[i]);
        q = (p < pwm_cfg_pkg::HI_LEN) ? ((p < pwm_cfg_pkg::HI_LEN - p - 11'h001) ? p : 11'(pwm_cfg_pkg::HI_LEN - p - 11'h001)) : 11'h000;
        if (q > 11'(pwm_cfg_pkg::RAMP_LEN)) q = 11'(pwm_cfg_pkg::RAMP_LEN);
        span = (peak > min_duty) ? 15'(peak - min_duty) * 15'(q) : 15'h0000;
        raw = 16'(min_duty) + 16'(span >> pwm_cfg_pkg::RAMP_SHIFT);
      end
      // Factor in eighths: 8, 9, 10, 12
      unique case (overmod_level)
        2'h0: sc = 12'(raw[7:0]) * 12'h008;
        2'h1: sc = 12'(raw[7:0]) * 12'h009;
        2'h2: sc = 12'(raw[7:0]) * 12'h00a;
        2'h3: sc = 12'(raw[7:0]) * 12'h00c;
      endcase
      duty[i] = sc[11] ? pwm_cfg_pkg::DUTY_FULL : sc[10:3];
    end
  end
endmodule : duty_shaper

// ---- core/bemf_zero_cross.sv ----
// Bemf window and zero-crossing detection on the floating phase
`timescale 1ns/1ps
module bemf_zero_cross (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Configuration
  input wire logic run,
  input wire logic [4:0] bw_code,
  // Position in sector (direction corrected), floating phase, bridge state
  input wire logic [7:0] pos,
  input wire logic [1:0] undriven,
  input wire logic pwm_on,
  // Sensed levels
  input wire logic [9:0] sense_a,
  input wire logic [9:0] sense_b,
  input wire logic [9:0] sense_c,
  input wire logic [9:0] bus_sense,
  // Results
  output logic win_open,
  output logic zc,
  output logic [7:0] zc_pos
);
  typedef struct packed {
    logic armed;
    logic done;
    logic above;
    logic [1:0] und;
    logic zc;
    logic [7:0] zc_pos;
  } zc_state_t;

  zc_state_t st_r, st_nxt;

  // Window width in angle counts
  function automatic logic [8:0] win_width(input logic [4:0] code);
    int w;
    w = (int'(code) + 1) * pwm_cfg_pkg::BW_STEP_TENTHS * pwm_cfg_pkg::SECTOR / pwm_cfg_pkg::SECTOR_TENTHS;
    if (code == pwm_cfg_pkg::BW_FULL) w = pwm_cfg_pkg::SECTOR;
    return 9'(w);
  endfunction : win_width

  // One crossing per window; re-armed when the floating phase changes
  always_comb begin
    logic [8:0] half;
    logic [9:0] lvl;
    logic [9:0] ref_lvl;
    logic above_now;
    half = win_width(bw_code) >> 1;
    win_open = run && ({1'b0, pos} >= 9'(pwm_cfg_pkg::MID) - half) && ({1'b0, pos} < 9'(pwm_cfg_pkg::MID) + half);
    lvl = (undriven == 2'h0) ? sense_a : (undriven == 2'h1) ? sense_b : sense_c;
    ref_lvl = pwm_on ? (bus_sense >> 1) : 10'h000;
    above_now = lvl > ref_lvl;
    st_nxt = st_r;
    st_nxt.zc = 1'b0;
    st_nxt.und = undriven;
    if (!win_open || undriven != st_r.und) begin
      st_nxt.armed = 1'b0;
      st_nxt.done = 1'b0;
    end else if (!st_r.done) begin
      if (!st_r.armed) begin
        st_nxt.armed = 1'b1;
        st_nxt.above = above_now;
      end else if (above_now != st_r.above) begin
        st_nxt.zc = 1'b1;
        st_nxt.zc_pos = pos;
        st_nxt.done = 1'b1;
      end
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign zc = st_r.zc;
  assign zc_pos = st_r.zc_pos;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  full_window_a: assert property (run && bw_code == 5'h1f |-> win_open) else $error("full window closed");
  narrow_window_a: assert property (bw_code == 5'h00 && (pos < 8'h7e || pos > 8'h81) |-> !win_open)
    else $error("narrow window too wide");
  zc_in_window_a: assert property (st_r.zc |-> $past(win_open) && $past(ce)) else $error("crossing outside window");
endmodule : bemf_zero_cross

// ---- core/three_phase_commutation_pwm.sv ----
// Top: register port, commutation timing, PWM carrier and gate outputs
`timescale 1ns/1ps
module three_phase_commutation_pwm (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // Sensed phase and bus levels
  input wire logic [9:0] phase_sense_a,
  input wire logic [9:0] phase_sense_b,
  input wire logic [9:0] phase_sense_c,
  input wire logic [9:0] bus_sense,
  // Gate drive, high side and low side per phase
  output logic phase_a_output_hs,
  output logic phase_a_output_ls,
  output logic phase_b_output_hs,
  output logic phase_b_output_ls,
  output logic phase_c_output_hs,
  output logic phase_c_output_ls
);
  typedef struct packed {
    logic [11:0] ctrl;
    logic [7:0] peak;
    logic [7:0] min_duty;
    logic [15:0] speed;
    logic [15:0] frac;
    logic [10:0] angle;
    logic [7:0] carrier;
    logic [7:0] zc_cnt;
    logic [2:0] hs;
    logic [2:0] ls;
    logic [31:0] rd_data;
  } top_state_t;

  localparam top_state_t ST_RST = '{
    ctrl: pwm_cfg_pkg::CTRL_RST,
    peak: pwm_cfg_pkg::PEAK_RST,
    min_duty: pwm_cfg_pkg::MIN_RST,
    speed: pwm_cfg_pkg::SPEED_RST,
    default: '0
  };

  top_state_t st_r, st_nxt;

  // Control fields
  logic shape;
  logic two_ph;
  logic dir;
  logic adv;
  logic run;
  logic [1:0] overmod_level;
  logic [4:0] bw;

  // Position and detection
  logic [2:0] sector;
  logic [7:0] pos_dir;
  logic [1:0] und;
  logic [2:0][7:0] duty;
  logic win_open;
  logic zc;
  logic [7:0] zc_pos;

  assign shape = st_r.ctrl[pwm_cfg_pkg::F_SHAPE];
  assign two_ph = st_r.ctrl[pwm_cfg_pkg::F_TWO_PH];
  assign dir = st_r.ctrl[pwm_cfg_pkg::F_DIR];
  assign adv = st_r.ctrl[pwm_cfg_pkg::F_ADV];
  assign run = st_r.ctrl[pwm_cfg_pkg::F_RUN];
  assign overmod_level = st_r.ctrl[pwm_cfg_pkg::F_OVM +: 2];
  assign bw = st_r.ctrl[pwm_cfg_pkg::F_BW +: 5];

  // Sector index and position, mirrored in reverse so the window stays centred
  assign sector = st_r.angle[10:8];
  assign pos_dir = dir ? ~st_r.angle[7:0] : st_r.angle[7:0];
  assign und = pwm_cfg_pkg::undriven_phase(sector);

  duty_shaper u_shaper (
    .shape(shape),
    .two_phase(two_ph),
    .overmod_level(overmod_level),
    .peak(st_r.peak),
    .min_duty(st_r.min_duty),
    .angle(st_r.angle),
    .duty(duty)
  );

  // Reference follows the gates actually driven on the bridge
  bemf_zero_cross u_bemf (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .run(run),
    .bw_code(bw),
    .pos(pos_dir),
    .undriven(und),
    .pwm_on(|st_r.hs),
    .sense_a(phase_sense_a),
    .sense_b(phase_sense_b),
    .sense_c(phase_sense_c),
    .bus_sense(bus_sense),
    .win_open(win_open),
    .zc(zc),
    .zc_pos(zc_pos)
  );

  // Next state: timing, correction, gates, register access
  always_comb begin
    logic [16:0] sum;
    logic signed [8:0] err;
    logic signed [8:0] adj;
    logic signed [17:0] spd;
    logic on;
    pwm_cfg_pkg::drive_t drv;
    sum = 17'h0_0000;
    err = 9'sh000;
    adj = 9'sh000;
    spd = 18'sh0_0000;
    on = 1'b0;
    drv = pwm_cfg_pkg::DRV_Z;
    st_nxt = st_r;

    // Free-running PWM carrier, 255 steps so duty 255 is always on
    st_nxt.carrier = (st_r.carrier == pwm_cfg_pkg::CARRIER_LAST) ? 8'h00 : st_r.carrier + 8'h01;

    // Commutation timer: phase accumulator steps the angle
    if (run) begin
      sum = 17'(st_r.frac) + 17'(st_r.speed);
      st_nxt.frac = sum[15:0];
      if (sum[16]) begin
        st_nxt.angle = dir ? pwm_cfg_pkg::ang_add(st_r.angle, pwm_cfg_pkg::CYCLE_LAST)
                           : pwm_cfg_pkg::ang_add(st_r.angle, 11'h001);
      end
    end

    // Early crossing pulls position forward and raises the rate
    if (run && zc) begin
      err = $signed({1'b0, pwm_cfg_pkg::MID}) - $signed({1'b0, zc_pos});
      adj = dir ? -(err >>> 1) : (err >>> 1);
      st_nxt.angle = pwm_cfg_pkg::ang_add(st_nxt.angle,
                                          adj[8] ? 11'(pwm_cfg_pkg::CYCLE + 12'(adj)) : 11'(adj));
      spd = $signed({2'b00, st_r.speed}) + 18'(err);
      if (spd < 18'sh0_0001) st_nxt.speed = 16'h0001;
      else if (spd > 18'sh0_ffff) st_nxt.speed = 16'hffff;
      else st_nxt.speed = spd[15:0];
      st_nxt.zc_cnt = st_r.zc_cnt + 8'h01;
    end

    // Gate states per phase
    for (int i = 0; i < 3; i++) begin
      on = st_r.carrier < duty[i];
      drv = pwm_cfg_pkg::table_drive(sector, 2'(i));
      st_nxt.hs[i] = 1'b0;
      st_nxt.ls[i] = 1'b0;
      if (run && shape) begin
        // Table drive; high phase chops its high side only
        st_nxt.hs[i] = (drv == pwm_cfg_pkg::DRV_HI) && on;
        st_nxt.ls[i] = (drv == pwm_cfg_pkg::DRV_LO);
      end else if (run && !(win_open && und == 2'(i))) begin
        // Complementary switching; the floating phase opens for sensing
        st_nxt.hs[i] = on;
        st_nxt.ls[i] = !on;
      end
    end

    // Register writes; a speed write overrides the correction
    if (wr_en) begin
      unique case (addr)
        pwm_cfg_pkg::ADDR_CTRL: st_nxt.ctrl = wr_data[11:0];
        pwm_cfg_pkg::ADDR_DUTY: begin
          st_nxt.peak = wr_data[7:0];
          st_nxt.min_duty = wr_data[pwm_cfg_pkg::F_MIN +: 8];
        end
        pwm_cfg_pkg::ADDR_SPEED: st_nxt.speed = wr_data[15:0];
        default: ;
      endcase
    end

    // Read data stand for one cycle, zero otherwise and when unmapped
    st_nxt.rd_data = 32'h0000_0000;
    if (rd_en) begin
      unique case (addr)
        pwm_cfg_pkg::ADDR_CTRL: st_nxt.rd_data = {20'h0_0000, st_r.ctrl};
        pwm_cfg_pkg::ADDR_DUTY: st_nxt.rd_data = {16'h0000, st_r.min_duty, st_r.peak};
        pwm_cfg_pkg::ADDR_SPEED: st_nxt.rd_data = {16'h0000, st_r.speed};
        pwm_cfg_pkg::ADDR_STATUS: st_nxt.rd_data = {3'h0, st_r.angle, win_open, adv && two_ph,
                                                    st_r.zc_cnt, 5'h00, sector + 3'h1};
        default: st_nxt.rd_data = 32'h0000_0000;
      endcase
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= ST_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state
  assign rd_data = st_r.rd_data;
  assign phase_a_output_hs = st_r.hs[0];
  assign phase_a_output_ls = st_r.ls[0];
  assign phase_b_output_hs = st_r.hs[1];
  assign phase_b_output_ls = st_r.ls[1];
  assign phase_c_output_hs = st_r.hs[2];
  assign phase_c_output_ls = st_r.ls[2];

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Sequences for stepping and correction
  sequence fwd_step_s;
    $past(ce && run && !dir && !zc) && sector != $past(sector);
  endsequence

  sequence rev_step_s;
    $past(ce && run && dir && !zc) && sector != $past(sector);
  endsequence

  sequence zc_early_s;
    ce && run && zc && zc_pos < 8'h7c && st_r.speed < 16'hff00 && !(wr_en && addr == pwm_cfg_pkg::ADDR_SPEED);
  endsequence

  sequence speed_up_s;
    st_r.speed > $past(st_r.speed) ##0 st_r.zc_cnt == $past(st_r.zc_cnt) + 8'h01;
  endsequence

  gate_excl_a: assert property ((st_r.hs & st_r.ls) == 3'h0) else $error("both switches of a phase on");
  run_off_a: assert property (ce && !run |=> st_r.hs == 3'h0 && st_r.ls == 3'h0)
    else $error("gates on while stopped");
  rd_idle_a: assert property (ce && !rd_en |=> st_r.rd_data == 32'h0000_0000)
    else $error("read data left standing");
  float_off_a: assert property (ce && run && shape && und == 2'h0 |=> !st_r.hs[0] && !st_r.ls[0])
    else $error("floating phase driven");
  low_phase_a: assert property (ce && run && shape && pwm_cfg_pkg::table_drive(sector, 2'h1) == pwm_cfg_pkg::DRV_LO
                                |=> st_r.ls[1] && !st_r.hs[1]) else $error("low phase not low side");
  fwd_order_a: assert property (fwd_step_s |-> sector == (($past(sector) == 3'h5) ? 3'h0 : $past(sector) + 3'h1))
    else $error("forward state order broken");
  rev_order_a: assert property (rev_step_s |-> sector == (($past(sector) == 3'h0) ? 3'h5 : $past(sector) - 3'h1))
    else $error("reverse state order broken");
  two_phase_low_a: assert property (ce && run && !shape && two_ph |=> st_r.ls != 3'h0)
    else $error("no phase held low");
  three_phase_on_a: assert property (ce && run && !shape && !two_ph && !win_open |=> (st_r.hs | st_r.ls) == 3'h7)
    else $error("phase not switching");
  ovm_sat_a: assert property (shape && overmod_level == 2'h3 && st_r.min_duty >= 8'hab && st_r.peak >= st_r.min_duty
                              |-> duty == {3{pwm_cfg_pkg::DUTY_FULL}}) else $error("overmod not saturated");
  ovm_off_a: assert property (shape && overmod_level == 2'h0 && st_r.peak == st_r.min_duty |-> duty == {3{st_r.peak}})
    else $error("duty scaled with overmod off");
  speed_track_a: assert property (zc_early_s |=> speed_up_s) else $error("rate not raised on early crossing");
endmodule : three_phase_commutation_pwm

// ---- tb/bridge_model.sv ----
// Bridge and motor model: phase levels from the gate drive, bemf on a floating winding
`timescale 1ns/1ps
module bridge_model (
  // Clock and control
  input wire logic clk,
  input wire logic bemf_en,
  // Gate drive, index 0 is phase A
  input wire logic [2:0] hs,
  input wire logic [2:0] ls,
  // Sensed levels
  output logic [9:0] sense_a,
  output logic [9:0] sense_b,
  output logic [9:0] sense_c,
  output logic [9:0] bus_level
);
  logic [6:0] tick_r = 7'h00;
  logic [9:0] lvl [3];
  // Free-running count sets the bemf swing period
  always_ff @(posedge clk) tick_r <= tick_r + 7'h01;
  // Floating winding stays at ground unless asked, so a quiet run gets no corrections
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (hs[i]) lvl[i] = bus_level;
      else if (ls[i]) lvl[i] = 10'h000;
      else lvl[i] = (bemf_en && tick_r[6]) ? 10'h3f0 : 10'h000;
    end
  end
  assign bus_level = 10'h300;
  assign sense_a = lvl[0];
  assign sense_b = lvl[1];
  assign sense_c = lvl[2];
endmodule : bridge_model

// ---- tb/three_phase_commutation_pwm_test.sv ----
// Self-checking bench for the commutation PWM block
`timescale 1ns/1ps
module three_phase_commutation_pwm_test;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic bemf_en = 1'b0;
  logic [31:0] rd_data;
  logic [9:0] sa, sb, sc, bus;
  logic [2:0] hs, ls;
  int n_mismatch = 0;
  int num_checks = 0;
  // Gate patterns {a_hs,a_ls,b_hs,b_ls,c_hs,c_ls} per state; entry 0 cannot occur
  logic [5:0] tbl [7] = '{6'h3f, 6'h06, 6'h24, 6'h21, 6'h09, 6'h18, 6'h12};

  three_phase_commutation_pwm dut_u (.clk(clk), .sys_rst(sys_rst), .ce(ce), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .phase_sense_a(sa), .phase_sense_b(sb), .phase_sense_c(sc), .bus_sense(bus),
    .phase_a_output_hs(hs[0]), .phase_a_output_ls(ls[0]), .phase_b_output_hs(hs[1]),
    .phase_b_output_ls(ls[1]), .phase_c_output_hs(hs[2]), .phase_c_output_ls(ls[2]));
  bridge_model bridge_u (.clk(clk), .bemf_en(bemf_en), .hs(hs), .ls(ls),
    .sense_a(sa), .sense_b(sb), .sense_c(sc), .bus_level(bus));

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Bus cycles: strobes one cycle wide, read data taken in the cycle after
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : reg_rd

  // Readback, read-only status and an unmapped hole
  task automatic test_regs;
    logic [31:0] d;
    reg_wr(pwm_cfg_pkg::ADDR_DUTY, 32'h0000_1234);
    reg_rd(pwm_cfg_pkg::ADDR_DUTY, d);
    check(d, 32'h0000_1234);
    // Read data gone next cycle; gates stay off while stopped
    @(posedge clk);
    ce <= 1'b0;
    #1 check(rd_data, 32'h0000_0000);
    check({26'h0, hs, ls}, 32'h0000_0000);
    // A write while frozen is lost
    reg_wr(pwm_cfg_pkg::ADDR_DUTY, 32'h0000_5678);
    ce <= 1'b1;
    reg_rd(pwm_cfg_pkg::ADDR_DUTY, d);
    check(d, 32'h0000_1234);
    // Advance with two-phase raises the conflict bit; run stays off, state 1
    reg_wr(pwm_cfg_pkg::ADDR_CTRL, 32'h0000_000a);
    reg_rd(pwm_cfg_pkg::ADDR_STATUS, d);
    check({31'h0, d[16]}, 32'h0000_0001);
    check({29'h0, d[2:0]}, 32'h0000_0001);
    reg_rd(8'h10, d);
    check(d, 32'h0000_0000);
    $display("test_regs done");
  endtask : test_regs

  // Full-duty six-step walk; gate pattern checked on every read, state order on every state change
  task automatic test_seq(input logic rev);
    logic [31:0] d;
    logic [2:0] st, prev, nxt;
    int changes;
    changes = 0;
    prev = 3'h0;
    reg_wr(pwm_cfg_pkg::ADDR_DUTY, 32'h0000_ffff);
    reg_wr(pwm_cfg_pkg::ADDR_SPEED, 32'h0000_ffff);
    reg_wr(pwm_cfg_pkg::ADDR_CTRL, 32'h0000_0fc1 | {29'h0, rev, 2'h0});
    for (int i = 0; i < 3000 && changes < 7; i++) begin
      reg_rd(pwm_cfg_pkg::ADDR_STATUS, d);
      st = d[2:0];
      check({26'h0, hs[0], ls[0], hs[1], ls[1], hs[2], ls[2]}, {26'h0, tbl[st]});
      if (prev != 3'h0 && st != prev) begin
        nxt = rev ? ((prev == 3'h1) ? 3'h6 : prev - 3'h1) : ((prev == 3'h6) ? 3'h1 : prev + 3'h1);
        check({29'h0, st}, {29'h0, nxt});
        changes++;
      end
      prev = st;
    end
    if (changes < 7) begin
      n_mismatch++;
      stop_test();
    end
    $display("test_seq direction %0d done", rev);
  endtask : test_seq

  // High-side on-time over one carrier period for each overmod code
  task automatic test_ovm;
    logic [7:0] lvl [5] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'hc0};
    logic [1:0] code [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    logic [8:0] exp [5] = '{9'd128, 9'd144, 9'd160, 9'd192, 9'd255};
    int cnt;
    for (int k = 0; k < 5; k++) begin
      reg_wr(pwm_cfg_pkg::ADDR_DUTY, {16'h0000, lvl[k], lvl[k]});
      reg_wr(pwm_cfg_pkg::ADDR_CTRL, 32'h0000_0801 | {26'h0, code[k], 4'h0});
      repeat (4) @(posedge clk);
      cnt = 0;
      repeat (255) begin
        @(posedge clk);
        #1 check({29'h0, hs & ls}, 32'h0000_0000);
        if (|hs) cnt++;
      end
      check(cnt, {23'h0, exp[k]});
    end
    $display("test_ovm done");
  endtask : test_ovm

  // Sine drive: two-phase holds one phase low a whole carrier period, three-phase never does
  task automatic test_two_phase(input logic two);
    int hc [3], lc [3];
    logic held;
    reg_wr(pwm_cfg_pkg::ADDR_SPEED, 32'h0000_0100);
    reg_wr(pwm_cfg_pkg::ADDR_DUTY, 32'h0000_00ff);
    reg_wr(pwm_cfg_pkg::ADDR_CTRL, 32'h0000_0800 | {30'h0, two, 1'b0});
    repeat (4) @(posedge clk);
    hc = '{0, 0, 0};
    lc = '{0, 0, 0};
    repeat (255) begin
      @(posedge clk);
      #1;
      for (int i = 0; i < 3; i++) begin
        hc[i] += hs[i];
        lc[i] += ls[i];
      end
    end
    held = 1'b0;
    for (int i = 0; i < 3; i++) held |= (hc[i] == 0 && lc[i] == 255);
    check({31'h0, held}, {31'h0, two});
    $display("test_two_phase %0d done", two);
  endtask : test_two_phase

  // Swinging floating winding must be seen as zero crossings
  task automatic test_zero_cross;
    logic [31:0] d0, d1;
    reg_wr(pwm_cfg_pkg::ADDR_DUTY, 32'h0000_ffff);
    reg_wr(pwm_cfg_pkg::ADDR_SPEED, 32'h0000_ffff);
    reg_wr(pwm_cfg_pkg::ADDR_CTRL, 32'h0000_0fc1);
    reg_rd(pwm_cfg_pkg::ADDR_STATUS, d0);
    bemf_en <= 1'b1;
    repeat (2000) @(posedge clk);
    reg_rd(pwm_cfg_pkg::ADDR_STATUS, d1);
    check({31'h0, d1[15:8] != d0[15:8]}, 32'h0000_0001);
    bemf_en <= 1'b0;
    $display("test_zero_cross done");
  endtask : test_zero_cross

  // Hang guard, well over the run time of all tests
  initial begin
    #400_000;
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    test_regs();
    test_seq(1'b0);
    test_seq(1'b1);
    test_ovm();
    test_two_phase(1'b1);
    test_two_phase(1'b0);
    test_zero_cross();
    stop_test();
  end
endmodule : three_phase_commutation_pwm_test
